// *** core/dsbc_sync_button_ctrl.sv ***
// dds sync in/out, phase accumulator, register slave and front-panel buttons
// Overview of operation
// - enabled sync rise reloads accumulator with offset
// - pulse cycle marker at each new cycle
// - control bit 31 enables sync input
// - control bit 30 enables cycle marker
// - marker width is field times 10ns, min 10ns
// - button A steps eight presets, one LED lit
// - button B steps eight presets, one LED dark
// - coding button inverts coding select pin
// - after board init coding select is high
// - cpu reset button resets processor and board
// - reconfigure button reloads and reinitialises board
// - 24-bit accumulator, frequency is update rate times increment over 2^24
// - standalone updates at 200kHz, serial clock 10MHz
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "dsbc_params.svh"
module dsbc_sync_button_ctrl #(
  parameter int DEBOUNCE_CYC = `DSBC_DEBOUNCE_CYC,
  parameter int UPDATE_CYC   = `DSBC_UPDATE_CYC
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // apb slave
  input  dsbc_pkg::dsbc_apb_req_t    apbReq,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // sync pins
  input  wire logic                  syncIn,
  output logic                       syncOut,
  // front panel, buttons active high while pressed
  input  wire logic [4:0]            buttons,
  output logic [7:0]                 frequencyIndicatorLeds,
  output logic                       codingSelectPin,
  output logic                       reconfigureReq,
  output logic                       cpuResetReq,
  // dds to dac path
  output logic                       dacUpdate,
  output logic                       serialClk,
  output logic [23:0]                ddsPhase
);
  //----------------------------------------------------------------
  // lookup functions
  //----------------------------------------------------------------
  function automatic logic [23:0] presetInc(input dsbc_pkg::dsbc_freqset_t s,
                                            input logic [2:0] i);
    logic [23:0] v;
    v = 24'h00_0000;
    if (s == dsbc_pkg::FREQ_SET_DARK) begin
      v = 24'h10_0000 >> (2 * i);
    end else begin
      unique case (i)
        3'd0: v = 24'h08_0000;
        3'd1: v = 24'h04_0000;
        3'd2: v = 24'h02_0000;
        3'd3: v = 24'h01_4800;
        3'd4: v = 24'h00_8300;
        3'd5: v = 24'h0C_CD00;
        3'd6: v = 24'h01_0000;
        3'd7: v = 24'h00_0100;
      endcase
    end
    return v;
  endfunction

  function automatic logic [7:0] ledPattern(input dsbc_pkg::dsbc_freqset_t s,
                                            input logic [2:0] i);
    logic [7:0] oneHot;
    oneHot = 8'h01 << i;
    return (s == dsbc_pkg::FREQ_SET_DARK) ? ~oneHot : oneHot;
  endfunction

  function automatic logic [31:0] widthCycles(input logic [29:0] field);
    logic [31:0] units;
    units = (field == 30'h0000_0000) ? 32'h0000_0001 : {2'b00, field};
    return 32'(units * `DSBC_WIDTH_UNIT_CYC);
  endfunction

  //----------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------
  logic [31:0]             syncCtrl_r;
  logic [23:0]             phaseOffset_r;
  logic [23:0]             phaseIncReg_r;
  logic                    guiMode_r;
  logic [4:0]              btnRelease;
  logic                    boardInit;
  logic                    syncMeta_r;
  logic                    syncStable_r;
  logic                    syncPrev_r;
  logic                    syncRise;
  logic                    restart;
  dsbc_pkg::dsbc_freqset_t freqSet_r;
  logic [2:0]              freqIdx_r;
  logic [15:0]             updCnt_r;
  logic                    updTick;
  logic [23:0]             activeInc;
  logic [24:0]             accSum;
  logic                    cycleEvt;
  logic [31:0]             pulseCnt_r;
  logic [31:0]             pulseCnt_nxt;
  logic [7:0]              sclkCnt_r;
  logic                    setupPh;
  logic                    wrEn;
  logic [31:0]             readMux;
  logic                    addrHit;

  //----------------------------------------------------------------
  // buttons
  //----------------------------------------------------------------
  for (genvar b = 0; b < 5; b++) begin : g_btn
    dsbc_debounce #(
      .CYCLES(DEBOUNCE_CYC)
    ) u_deb (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .rawIn       (buttons[b]),
      .releasePulse(btnRelease[b])
    );
  end

  // either panel reset reinitialises the registers, panel state and accumulator, but not the update and serial clock counters
  assign boardInit = btnRelease[`DSBC_BTN_RECONFIG] | btnRelease[`DSBC_BTN_CPU_RESET];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reconfigureReq <= 1'b0;
      cpuResetReq    <= 1'b0;
    end else begin
      reconfigureReq <= btnRelease[`DSBC_BTN_RECONFIG];
      cpuResetReq    <= btnRelease[`DSBC_BTN_CPU_RESET];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || boardInit) begin
      codingSelectPin <= 1'b1;
    end else if (btnRelease[`DSBC_BTN_CODING]) begin
      codingSelectPin <= ~codingSelectPin;
    end
  end

  // switching set restarts at the first preset of that set
  always_ff @(posedge mclk) begin
    if (!reset_n || boardInit) begin
      freqSet_r <= dsbc_pkg::FREQ_SET_LIT;
      freqIdx_r <= 3'd0;
    end else if (btnRelease[`DSBC_BTN_FREQ_A]) begin
      freqSet_r <= dsbc_pkg::FREQ_SET_LIT;
      freqIdx_r <= (freqSet_r == dsbc_pkg::FREQ_SET_LIT) ? freqIdx_r + 3'd1 : 3'd0;
    end else if (btnRelease[`DSBC_BTN_FREQ_B]) begin
      freqSet_r <= dsbc_pkg::FREQ_SET_DARK;
      freqIdx_r <= (freqSet_r == dsbc_pkg::FREQ_SET_DARK) ? freqIdx_r + 3'd1 : 3'd0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      frequencyIndicatorLeds <= 8'h01;
    end else begin
      frequencyIndicatorLeds <= ledPattern(freqSet_r, freqIdx_r);
    end
  end

  //----------------------------------------------------------------
  // apb slave, zero wait states
  //----------------------------------------------------------------
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign wrEn    = apbReq.psel & apbReq.penable & pready & apbReq.pwrite;

  always_comb begin
    addrHit = 1'b1;
    readMux = 32'h0000_0000;
    unique case (apbReq.paddr)
      `DSBC_OFF_SYNC_CTRL: readMux = syncCtrl_r;
      `DSBC_OFF_PHASE_OFF: readMux = {8'h00, phaseOffset_r};
      `DSBC_OFF_PHASE_INC: readMux = {8'h00, phaseIncReg_r};
      `DSBC_OFF_MODE:      readMux = {31'h0000_0000, guiMode_r};
      `DSBC_OFF_STATUS:    readMux = {18'h0_0000, syncOut, codingSelectPin, freqSet_r,
                                      freqIdx_r, frequencyIndicatorLeds};
      `DSBC_OFF_PHASE_ACC: readMux = {8'h00, ddsPhase};
      default:             addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPh;
      pslverr <= setupPh & ~addrHit;
      prdata  <= (setupPh & ~apbReq.pwrite) ? readMux : 32'h0000_0000;
    end
  end

  // writes to the status words are ignored; soft reset wins over a write
  always_ff @(posedge mclk) begin
    if (!reset_n || boardInit) begin
      syncCtrl_r    <= `DSBC_RST_SYNC_CTRL;
      phaseOffset_r <= `DSBC_RST_PHASE_OFF;
      phaseIncReg_r <= `DSBC_RST_PHASE_INC;
      guiMode_r     <= 1'b0;
    end else if (wrEn) begin
      unique case (apbReq.paddr)
        `DSBC_OFF_SYNC_CTRL: syncCtrl_r    <= apbReq.pwdata;
        `DSBC_OFF_PHASE_OFF: phaseOffset_r <= apbReq.pwdata[23:0];
        `DSBC_OFF_PHASE_INC: phaseIncReg_r <= apbReq.pwdata[23:0];
        `DSBC_OFF_MODE:      guiMode_r     <= apbReq.pwdata[0];
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------------
  // sync input edge
  //----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      syncMeta_r   <= 1'b0;
      syncStable_r <= 1'b0;
      syncPrev_r   <= 1'b0;
    end else begin
      syncMeta_r   <= syncIn;
      syncStable_r <= syncMeta_r;
      syncPrev_r   <= syncStable_r;
    end
  end

  assign syncRise = syncStable_r & ~syncPrev_r;
  assign restart  = syncRise & syncCtrl_r[`DSBC_BIT_SYNC_IN_EN];

  //----------------------------------------------------------------
  // dds timing and accumulator
  //----------------------------------------------------------------
  assign updTick = (updCnt_r == 16'(UPDATE_CYC - 1));

  // restart also realigns the update grid to the sync edge
  always_ff @(posedge mclk) begin
    if (!reset_n || updTick || restart) begin
      updCnt_r <= 16'h0000;
    end else begin
      updCnt_r <= updCnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dacUpdate <= 1'b0;
      sclkCnt_r <= 8'h00;
      serialClk <= 1'b0;
    end else begin
      dacUpdate <= updTick & ~restart;
      if (sclkCnt_r == 8'(`DSBC_SCLK_HALF_CYC - 1)) begin
        sclkCnt_r <= 8'h00;
        serialClk <= ~serialClk;
      end else begin
        sclkCnt_r <= sclkCnt_r + 8'h01;
      end
    end
  end

  assign activeInc = guiMode_r ? phaseIncReg_r : presetInc(freqSet_r, freqIdx_r);
  assign accSum    = {1'b0, ddsPhase} + {1'b0, activeInc};
  assign cycleEvt  = restart | (updTick & accSum[24]);

  always_ff @(posedge mclk) begin
    if (!reset_n || boardInit) begin
      ddsPhase <= 24'h00_0000;
    end else if (restart) begin
      ddsPhase <= phaseOffset_r;
    end else if (updTick) begin
      ddsPhase <= accSum[23:0];
    end
  end

  //----------------------------------------------------------------
  // cycle marker
  //----------------------------------------------------------------
  // a new cycle inside a running pulse restarts the full width
  always_comb begin
    pulseCnt_nxt = 32'h0000_0000;
    if (!syncCtrl_r[`DSBC_BIT_SYNC_OUT_EN]) begin
      pulseCnt_nxt = 32'h0000_0000;
    end else if (cycleEvt) begin
      pulseCnt_nxt = widthCycles(syncCtrl_r[`DSBC_WIDTH_MSB:0]);
    end else if (pulseCnt_r != 32'h0000_0000) begin
      pulseCnt_nxt = pulseCnt_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pulseCnt_r <= 32'h0000_0000;
      syncOut    <= 1'b0;
    end else begin
      pulseCnt_r <= pulseCnt_nxt;
      syncOut    <= (pulseCnt_nxt != 32'h0000_0000);
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_sync_restart_load: assert property (restart && !boardInit |=> ddsPhase == $past(phaseOffset_r))
    else $error("accumulator not loaded with phase offset on sync edge");
  a_sync_in_ignored: assert property (syncRise && !syncCtrl_r[31] && !updTick && !boardInit
                                      |=> ddsPhase == $past(ddsPhase))
    else $error("disabled sync input moved the accumulator");
  a_marker_on_cycle: assert property (cycleEvt && syncCtrl_r[30] |=> syncOut)
    else $error("no cycle marker at new cycle");
  a_marker_disabled: assert property (!syncCtrl_r[30] |=> !syncOut)
    else $error("cycle marker driven while disabled");
  a_width_minimum: assert property (cycleEvt && syncCtrl_r[30] && syncCtrl_r[29:0] == 30'h0
                                    ##1 (!cycleEvt && syncCtrl_r[30])[*2] |=> !syncOut
                                    and $past(syncOut) and $past(syncOut, 2))
    else $error("zero width field did not give one 10ns pulse");
  a_width_three: assert property (cycleEvt && syncCtrl_r[30] && syncCtrl_r[29:0] == 30'h3
                                  |=> syncOut[*6] ##1 (!syncOut || $past(cycleEvt)))
    else $error("width field 3 did not give 30ns pulse");
  a_leds_lit: assert property (freqSet_r == dsbc_pkg::FREQ_SET_LIT && $stable(freqSet_r)
                               && $stable(freqIdx_r) |-> $onehot(frequencyIndicatorLeds))
    else $error("lit set does not show exactly one lit led");
  a_leds_dark: assert property (freqSet_r == dsbc_pkg::FREQ_SET_DARK && $stable(freqSet_r)
                                && $stable(freqIdx_r) |-> $onehot(~frequencyIndicatorLeds))
    else $error("dark set does not show exactly one dark led");
  a_coding_toggle: assert property (btnRelease[4] && !boardInit
                                    |=> codingSelectPin != $past(codingSelectPin))
    else $error("coding button did not invert select pin");
  a_coding_init: assert property (boardInit |=> codingSelectPin && syncCtrl_r == 32'h0)
    else $error("board init left coding select low");
  a_cpu_reset_out: assert property (btnRelease[1] |=> cpuResetReq && ddsPhase == 24'h0)
    else $error("cpu reset button did not reset board");
  a_reconfig_out: assert property (btnRelease[0] |=> reconfigureReq ##1 !reconfigureReq)
    else $error("reconfigure request not a single pulse");
  a_acc_step: assert property (updTick && !restart && !boardInit
                               |=> ddsPhase == 24'($past(ddsPhase) + $past(activeInc)))
    else $error("accumulator step wrong");
  a_update_rate: assert property (dacUpdate |-> updCnt_r == 16'h0
                                  && $past(updCnt_r) == 16'(UPDATE_CYC - 1))
    else $error("dac update not on 200kHz grid");
  a_sclk_rate: assert property ($changed(serialClk) |-> $past(sclkCnt_r) == 8'd9)
    else $error("serial clock half period wrong");

  c_sync_restart: cover property (restart);
  c_marker_pulse: cover property (syncOut ##1 !syncOut);
  c_coding_low:   cover property (!codingSelectPin);
  c_dark_set:     cover property (freqSet_r == dsbc_pkg::FREQ_SET_DARK && freqIdx_r == 3'd7);
endmodule // dsbc_sync_button_ctrl

// *** core/dsbc_params.svh ***
// offsets, field positions, reset values and timing counts of the dds sync block
`ifndef DSBC_PARAMS_SVH
`define DSBC_PARAMS_SVH

`define DSBC_CLK_MHZ          200
`define DSBC_CLK_PERIOD_NS    5
`define DSBC_WIDTH_UNIT_NS    10
`define DSBC_WIDTH_UNIT_CYC   ((`DSBC_WIDTH_UNIT_NS + `DSBC_CLK_PERIOD_NS - 1) / `DSBC_CLK_PERIOD_NS)
`define DSBC_UPDATE_KHZ       200
`define DSBC_UPDATE_CYC       ((`DSBC_CLK_MHZ * 1000) / `DSBC_UPDATE_KHZ)
`define DSBC_SCLK_MHZ         10
`define DSBC_SCLK_HALF_CYC    (`DSBC_CLK_MHZ / (2 * `DSBC_SCLK_MHZ))
`define DSBC_DEBOUNCE_US      5000
`define DSBC_DEBOUNCE_CYC     (`DSBC_DEBOUNCE_US * `DSBC_CLK_MHZ)

`define DSBC_OFF_SYNC_CTRL    8'h00
`define DSBC_OFF_PHASE_OFF    8'h04
`define DSBC_OFF_PHASE_INC    8'h08
`define DSBC_OFF_MODE         8'h0C
`define DSBC_OFF_STATUS       8'h10
`define DSBC_OFF_PHASE_ACC    8'h14

`define DSBC_BIT_SYNC_IN_EN   31
`define DSBC_BIT_SYNC_OUT_EN  30
`define DSBC_WIDTH_MSB        29

`define DSBC_RST_SYNC_CTRL    32'h0000_0000
`define DSBC_RST_PHASE_OFF    24'h00_0000
`define DSBC_RST_PHASE_INC    24'h00_0000

`define DSBC_BTN_RECONFIG     0
`define DSBC_BTN_CPU_RESET    1
`define DSBC_BTN_FREQ_A       2
`define DSBC_BTN_FREQ_B       3
`define DSBC_BTN_CODING       4

`endif

// *** core/dsbc_pkg.sv ***
// types shared by the dds sync and button control block
package dsbc_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dsbc_apb_req_t;

  typedef enum logic {
    FREQ_SET_LIT,
    FREQ_SET_DARK
  } dsbc_freqset_t;

endpackage

// *** core/dsbc_debounce.sv ***
// button synchroniser and debouncer giving one pulse per release
`timescale 1ns/10ps
module dsbc_debounce #(
  parameter int CYCLES = 1000
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // button
  input  wire logic rawIn,
  output logic      releasePulse
);
  localparam int CW = $clog2(CYCLES + 1);

  logic          meta_r;
  logic          syncd_r;
  logic          stable_r;
  logic [CW-1:0] cnt_r;
  logic          settle;

  assign settle = (cnt_r == CW'(CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_r  <= 1'b0;
      syncd_r <= 1'b0;
    end else begin
      meta_r  <= rawIn;
      syncd_r <= meta_r;
    end
  end

  // level must hold for CYCLES before it is believed
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stable_r     <= 1'b0;
      cnt_r        <= '0;
      releasePulse <= 1'b0;
    end else begin
      releasePulse <= 1'b0;
      if (syncd_r == stable_r) begin
        cnt_r <= '0;
      end else if (settle) begin
        cnt_r        <= '0;
        stable_r     <= syncd_r;
        releasePulse <= stable_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // dsbc_debounce

// *** tb/dsbc_sync_partner.sv ***
// sync source and marker-measuring instrument beside the dds sync block
`timescale 1ns/10ps
module dsbc_sync_partner (
  // clock
  input  wire logic   mclk,
  // commands and observed pins
  input  wire logic   fireReq,
  input  wire logic   syncOut,
  input  wire logic   codingSelectPin,
  // driven pin and measurements
  output logic        syncIn,
  output logic [31:0] widthLast,
  output logic [31:0] markCount,
  output logic        distorted
);
  // ----------------
  // source and meter
  // ----------------
  logic [31:0] run;
  int          hold;

  initial begin
    syncIn = 1'b0;
    widthLast = '0;
    markCount = '0;
    run = '0;
    hold = 0;
  end

  // source idles low; each request gives one clean rise held a few clocks
  always @(posedge mclk) begin
    if (fireReq) hold <= 3;
    else if (hold > 0) hold <= hold - 1;
    syncIn <= fireReq || hold > 1;
  end

  // width is counted in clocks, reported at the falling edge of the marker
  always @(posedge mclk) begin
    if (syncOut === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      widthLast <= run;
      markCount <= markCount + 1;
      run <= '0;
    end
  end

  // a low select level means the dac output would be a wrong sine
  assign distorted = (codingSelectPin !== 1'b1);
endmodule // dsbc_sync_partner

// *** tb/tb.sv ***
// self-checking bench of the dds sync and button control block
`timescale 1ns/10ps
module tb;
  // ----------------
  // signals and parts
  // ----------------
  localparam int DEB = 4;
  localparam int UPD = 20;
  dsbc_pkg::dsbc_apb_req_t req;
  logic                    mclk, reset_n, pready, pslverr, err, syncIn, syncOut;
  logic                    coding, reconfReq, cpuReq, dacUpdate, serialClk;
  logic                    fireReq, distorted, sawReconf, sawCpu;
  logic [31:0]             prdata, rd, widthLast, markCount, m0;
  logic [23:0]             ddsPhase, p0;
  logic [7:0]              leds;
  logic [4:0]              buttons;
  int                      n_mismatch, compares, n;
  int                      wf[3] = '{0, 1, 5};

  dsbc_sync_button_ctrl #(.DEBOUNCE_CYC(DEB), .UPDATE_CYC(UPD)) dsbc_sync_button_ctrl_i (
    .mclk(mclk), .reset_n(reset_n), .apbReq(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .syncIn(syncIn), .syncOut(syncOut), .buttons(buttons),
    .frequencyIndicatorLeds(leds), .codingSelectPin(coding), .reconfigureReq(reconfReq),
    .cpuResetReq(cpuReq), .dacUpdate(dacUpdate), .serialClk(serialClk), .ddsPhase(ddsPhase));

  dsbc_sync_partner dsbc_sync_partner_i (
    .mclk(mclk), .fireReq(fireReq), .syncOut(syncOut), .codingSelectPin(coding),
    .syncIn(syncIn), .widthLast(widthLast), .markCount(markCount), .distorted(distorted));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (reconfReq === 1'b1) sawReconf <= 1'b1;
    if (cpuReq === 1'b1) sawCpu <= 1'b1;
  end

  // ----------------
  // tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) n_mismatch++;
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic fire();
    m0 = markCount;
    @(posedge mclk);
    fireReq <= 1'b1;
    @(posedge mclk);
    fireReq <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask

  task automatic push(input int b, input int hold = DEB + 4);
    @(posedge mclk);
    buttons[b] <= 1'b1;
    repeat (hold) @(posedge mclk);
    buttons[b] <= 1'b0;
    repeat (DEB + 8) @(posedge mclk);
  endtask

  // n counts edges until the watched pin has moved; bounded
  task automatic wait_dac();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (dacUpdate !== 1'b1 && n < 100);
    repeat (3) @(posedge mclk);
  endtask

  task automatic wait_sclk();
    logic s;
    s = serialClk;
    n = 0;
    while (serialClk === s && n < 50) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  // ----------------
  // tests
  // ----------------
  initial begin
    req = '0;
    reset_n = 1'b0;
    buttons = '0;
    fireReq = 1'b0;
    sawReconf = 1'b0;
    sawCpu = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk({24'h0, leds}, 32'h0000_0001);
    chk({31'h0, coding}, 32'h0000_0001);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h04, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test reset and map done");
    // frozen accumulator so only a restart can move the phase
    wr(8'h0C, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    wr(8'h04, 32'h0012_3456);
    wr(8'h00, 32'hC000_0003);
    rdchk(8'h00, 32'hC000_0003);
    fire();
    chk({8'h0, ddsPhase}, 32'h0012_3456);
    chk(widthLast, 32'h0000_0006);
    chk(markCount, m0 + 1);
    wr(8'h14, 32'h0000_0000);
    rdchk(8'h14, 32'h0012_3456);
    foreach (wf[i]) begin
      wr(8'h00, 32'hC000_0000 | 32'(wf[i]));
      fire();
      chk(widthLast, 32'(2 * (wf[i] == 0 ? 1 : wf[i])));
    end
    wr(8'h00, 32'h4000_0001);
    wr(8'h04, 32'h0000_0ABC);
    fire();
    chk({8'h0, ddsPhase}, 32'h0012_3456);
    chk(markCount, m0);
    wr(8'h00, 32'h8000_0001);
    fire();
    chk({8'h0, ddsPhase}, 32'h0000_0ABC);
    chk(markCount, m0);
    $display("test sync done");
    wr(8'h08, 32'h0000_0100);
    wait_dac();
    p0 = ddsPhase;
    wait_dac();
    chk(32'(n + 3), 32'(UPD));
    chk({8'h0, ddsPhase}, {8'h0, p0 + 24'h00_0100});
    wait_sclk();
    wait_sclk();
    chk(32'(n), 32'h0000_000A);
    wr(8'h08, 32'h0080_0000);
    wr(8'h00, 32'h4000_0002);
    m0 = markCount;
    repeat (60) @(posedge mclk);
    chk({31'h0, markCount > m0}, 32'h0000_0001);
    chk(widthLast, 32'h0000_0004);
    $display("test dds rates done");
    for (int k = 1; k <= 8; k++) begin
      push(2);
      chk({24'h0, leds}, 32'(8'h01 << (k % 8)));
    end
    push(3);
    chk({24'h0, leds}, 32'h0000_00FE);
    push(3);
    chk({24'h0, leds}, 32'h0000_00FD);
    push(2);
    chk({24'h0, leds}, 32'h0000_0001);
    push(4);
    chk({31'h0, coding}, 32'h0000_0000);
    chk({31'h0, distorted}, 32'h0000_0001);
    push(4);
    chk({31'h0, coding}, 32'h0000_0001);
    push(2, 2);
    chk({24'h0, leds}, 32'h0000_0001);
    $display("test buttons done");
    push(2);
    push(4);
    wr(8'h00, 32'hC000_0007);
    push(0);
    chk({24'h0, leds}, 32'h0000_0001);
    chk({31'h0, coding}, 32'h0000_0001);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_1001);
    chk({31'h0, sawReconf}, 32'h0000_0001);
    wr(8'h04, 32'h0000_0055);
    push(1);
    rdchk(8'h04, 32'h0000_0000);
    chk({31'h0, sawCpu}, 32'h0000_0001);
    $display("test board init done");
    wrap_up();
  end
endmodule // tb
